// ==== src/srpb_top.sv ====
// Register pointer and register bank of the temperature sensor.
// Assumes a byte-level serial engine on LINK_CLK and converter/alert logic on CLOCK.
`timescale 1ns/1ns
module srpb_top
	import srpb_pkg::*;
#(
	parameter int unsigned CYC_00 = PACE_CYC_00,
	parameter int unsigned CYC_01 = PACE_CYC_01,
	parameter int unsigned CYC_10 = PACE_CYC_10,
	parameter int unsigned CYC_11 = PACE_CYC_11
) (
	input  wire logic        CLOCK,
	input  wire logic        RST,
	input  wire logic        CE,
	input  wire logic        LINK_CLK,
	input  wire logic        LINK_START,
	input  wire logic        LINK_PTR_WR,
	input  wire logic        LINK_DATA_WR,
	input  wire logic        LINK_RD_NEXT,
	input  wire logic [7:0]  LINK_WDATA,
	output logic      [7:0]  LINK_RDATA,
	output logic             LINK_BUSY,
	input  wire logic [15:0] TEMP_IN,
	input  wire logic        TEMP_VALID,
	input  wire logic        ALERT_FLAG,
	output logic      [7:0]  PTR_OUT,
	output logic      [15:0] SETUP_OUT,
	output logic      [15:0] LOWER_OUT,
	output logic      [15:0] UPPER_OUT,
	output logic      [1:0]  CONV_PACE,
	output logic             CONV_TICK
);
	srpb_xfer_if #(.W(REQ_W)) l2c ();
	srpb_xfer_if #(.W(REG_W)) c2l ();

	logic                  link_rst_s1;
	logic                  link_rst;
	logic                  link_ce_s1;
	logic                  link_ce;
	srpb_phase_e           phase;
	logic [7:0]            msb_hold;
	logic [15:0]           snap;
	logic [15:0]           temperature_result;
	logic [15:0]           sel_value;
	logic [15:0]           last_sent;
	logic [PACE_CNT_W-1:0] pace_cnt;
	logic [PACE_CNT_W-1:0] pace_limit;
	logic                  req_ptr;
	logic                  req_reg;

	function automatic logic [PACE_CNT_W-1:0] pace_cycles(input logic [1:0] code);
		unique case (code)
			2'h0: pace_cycles = CYC_00[PACE_CNT_W-1:0];
			2'h1: pace_cycles = CYC_01[PACE_CNT_W-1:0];
			2'h2: pace_cycles = CYC_10[PACE_CNT_W-1:0];
			2'h3: pace_cycles = CYC_11[PACE_CNT_W-1:0];
		endcase
	endfunction : pace_cycles

	srpb_xfer u_l2c (
		.src_clk (LINK_CLK),
		.src_rst (link_rst),
		.src_ce  (link_ce),
		.dst_clk (CLOCK),
		.dst_rst (RST),
		.dst_ce  (CE),
		.x       (l2c)
	);

	srpb_xfer u_c2l (
		.src_clk (CLOCK),
		.src_rst (RST),
		.src_ce  (CE),
		.dst_clk (LINK_CLK),
		.dst_rst (link_rst),
		.dst_ce  (link_ce),
		.x       (c2l)
	);

	// Link-domain reset
	always_ff @(posedge LINK_CLK) begin
		link_rst_s1 <= RST;
		link_rst    <= link_rst_s1;
	end

	// Link-domain copy of the clock enable
	always_ff @(posedge LINK_CLK) begin
		link_ce_s1 <= CE;
		link_ce    <= link_ce_s1;
	end

	always_ff @(posedge LINK_CLK) begin
		if (link_rst) begin
			phase    <= SRPB_MSB;
			msb_hold <= 8'h00;
		end else if (link_ce) begin
			if (LINK_START || LINK_PTR_WR) begin
				phase <= SRPB_MSB;
			end else if (LINK_DATA_WR || LINK_RD_NEXT) begin
				phase <= (phase == SRPB_MSB) ? SRPB_LSB : SRPB_MSB;
				if (LINK_DATA_WR && phase == SRPB_MSB) begin
					msb_hold <= LINK_WDATA;
				end
			end
		end
	end

	always_comb begin
		l2c.push  = 1'b0;
		l2c.sdata = {REQ_PTR, 8'h00, LINK_WDATA};
		if (LINK_PTR_WR) begin
			l2c.push = 1'b1;
		end else if (LINK_DATA_WR && phase == SRPB_LSB) begin
			l2c.push  = 1'b1;
			l2c.sdata = {REQ_REG, msb_hold, LINK_WDATA};
		end
	end

	always_ff @(posedge LINK_CLK) begin
		if (link_rst) begin
			snap       <= TEMP_RESET;
			LINK_RDATA <= 8'h00;
			LINK_BUSY  <= 1'b0;
		end else if (link_ce) begin
			if (c2l.rvalid) begin
				snap <= c2l.rdata;
			end
			LINK_RDATA <= (phase == SRPB_MSB) ? snap[15:8] : snap[7:0];
			LINK_BUSY  <= l2c.busy;
		end
	end

	assign req_ptr = l2c.rvalid && l2c.rdata[REG_W] == REQ_PTR;
	assign req_reg = l2c.rvalid && l2c.rdata[REG_W] == REQ_REG;

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			PTR_OUT <= PTR_RESET;
		end else if (CE && req_ptr) begin
			PTR_OUT <= {6'h00, l2c.rdata[SEL_W-1:0]};
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			SETUP_OUT <= SETUP_RESET;
			LOWER_OUT <= THR_RESET;
			UPPER_OUT <= THR_RESET;
		end else if (CE && req_reg) begin
			unique case (PTR_OUT[SEL_W-1:0])
				SEL_TEMP:  ;
				SEL_SETUP: SETUP_OUT <= l2c.rdata[REG_W-1:0] & SETUP_RW_MASK;
				SEL_LOWER: LOWER_OUT <= l2c.rdata[REG_W-1:0];
				SEL_UPPER: UPPER_OUT <= l2c.rdata[REG_W-1:0];
			endcase
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			temperature_result <= TEMP_RESET;
		end else if (CE && TEMP_VALID) begin
			temperature_result <= TEMP_IN;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			sel_value <= TEMP_RESET;
		end else if (CE) begin
			unique case (PTR_OUT[SEL_W-1:0])
				SEL_TEMP:  sel_value <= temperature_result;
				SEL_SETUP: sel_value <= SETUP_OUT | SETUP_ONES
					| (16'(ALERT_FLAG) << ALERT_POS);
				SEL_LOWER: sel_value <= LOWER_OUT;
				SEL_UPPER: sel_value <= UPPER_OUT;
			endcase
		end
	end

	assign c2l.sdata = sel_value;
	assign c2l.push  = CE && !c2l.busy && sel_value != last_sent;

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			last_sent <= TEMP_RESET;
		end else if (c2l.push) begin
			last_sent <= sel_value;
		end
	end

	assign pace_limit = pace_cycles(SETUP_OUT[PACE_LSB+1:PACE_LSB]);

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			pace_cnt  <= '0;
			CONV_TICK <= 1'b0;
			CONV_PACE <= PACE_RESET;
		end else if (CE) begin
			CONV_PACE <= SETUP_OUT[PACE_LSB+1:PACE_LSB];
			CONV_TICK <= pace_cnt >= pace_limit - 1'b1;
			if (pace_cnt >= pace_limit - 1'b1) begin
				pace_cnt <= '0;
			end else begin
				pace_cnt <= pace_cnt + 1'b1;
			end
		end
	end

	property p_ptr_reset;
		@(posedge CLOCK) RST |=> PTR_OUT == PTR_RESET;
	endproperty
	a_ptr_reset: assert property (p_ptr_reset) else $error("pointer not zero after reset");

	property p_ptr_upper;
		@(posedge CLOCK) disable iff (RST) ##1 PTR_OUT[7:2] == 6'h00;
	endproperty
	a_ptr_upper: assert property (p_ptr_upper) else $error("pointer upper bits set");

	property p_sel_lower;
		@(posedge CLOCK) disable iff (RST)
			CE && PTR_OUT[1:0] == SEL_LOWER |=> sel_value == $past(LOWER_OUT);
	endproperty
	a_sel_lower: assert property (p_sel_lower) else $error("wrong register selected");

	property p_temp_ro;
		@(posedge CLOCK) disable iff (RST)
			req_reg && PTR_OUT[1:0] == SEL_TEMP && !TEMP_VALID |=> $stable(temperature_result);
	endproperty
	a_temp_ro: assert property (p_temp_ro) else $error("temperature changed by write");

	property p_pace_tick;
		@(posedge CLOCK) disable iff (RST)
			CE && pace_cnt == pace_limit - 1'b1 |=> CONV_TICK && pace_cnt == '0;
	endproperty
	a_pace_tick: assert property (p_pace_tick) else $error("conversion tick missed");

	property p_msb_first;
		@(posedge LINK_CLK) disable iff (link_rst)
			LINK_START |=> ##1 LINK_RDATA == $past(snap[15:8]);
	endproperty
	a_msb_first: assert property (p_msb_first) else $error("low byte sent first");

	property p_pace_reset;
		@(posedge CLOCK) RST |=> CONV_PACE == PACE_RESET && SETUP_OUT[7:6] == PACE_RESET;
	endproperty
	a_pace_reset: assert property (p_pace_reset) else $error("pace code wrong after reset");

	property p_ptr_hold;
		@(posedge CLOCK) disable iff (RST) !req_ptr ##1 !RST |-> $stable(PTR_OUT);
	endproperty
	a_ptr_hold: assert property (p_ptr_hold) else $error("pointer changed unbidden");
endmodule : srpb_top

// ==== src/srpb_pkg.sv ====
// Constants for the sensor register pointer bank.
// Assumes one core clock at CLK_MHZ and a byte-level link engine on its own clock.
// Behaviour
// - Eight-bit pointer; its two low bits are read/write and reset to zero.
// - Pointer bits seven to two always read zero and ignore writes.
// - Pointer code 0 temperature, 1 setup, 2 lower, 3 upper threshold.
// - Temperature result ignores host writes; setup and thresholds are read/write.
// - Pace code 00,01,10,11 gives 0.25,1,4,8 conversions per second.
// - Setup register is sixteen bits; every transfer moves the high byte first.
// - After reset the pace code is binary 10, four conversions per second.
package srpb_pkg;
	localparam int          PTR_W         = 8;
	localparam int          SEL_W         = 2;
	localparam int          REG_W         = 16;
	localparam int          REQ_W         = REG_W + 1;
	localparam logic [1:0]  SEL_TEMP      = 2'h0;
	localparam logic [1:0]  SEL_SETUP     = 2'h1;
	localparam logic [1:0]  SEL_LOWER     = 2'h2;
	localparam logic [1:0]  SEL_UPPER     = 2'h3;
	localparam logic [7:0]  PTR_RESET     = 8'h00;
	localparam logic [15:0] SETUP_RW_MASK = 16'h9fc0;
	localparam logic [15:0] SETUP_ONES    = 16'h4000;
	localparam logic [15:0] SETUP_RESET   = 16'h0080;
	localparam int          ALERT_POS     = 5;
	localparam int          PACE_LSB      = 6;
	localparam logic [1:0]  PACE_RESET    = 2'h2;
	localparam logic [15:0] TEMP_RESET    = 16'h0000;
	localparam logic [15:0] THR_RESET     = 16'h0000;
	localparam logic        REQ_PTR       = 1'b0;
	localparam logic        REQ_REG       = 1'b1;
	localparam int          CLK_MHZ       = 250;
	localparam int          PACE_MS_00    = 4000;
	localparam int          PACE_MS_01    = 1000;
	localparam int          PACE_MS_10    = 250;
	localparam int          PACE_MS_11    = 125;
	localparam int          PACE_CYC_00   = PACE_MS_00 * CLK_MHZ * 1000;
	localparam int          PACE_CYC_01   = PACE_MS_01 * CLK_MHZ * 1000;
	localparam int          PACE_CYC_10   = PACE_MS_10 * CLK_MHZ * 1000;
	localparam int          PACE_CYC_11   = PACE_MS_11 * CLK_MHZ * 1000;
	localparam int          PACE_CNT_W    = 30;
	typedef enum logic {SRPB_MSB, SRPB_LSB} srpb_phase_e;
endpackage : srpb_pkg

// ==== src/srpb_xfer_if.sv ====
// Carrier for one word crossing between two clock domains.
// Assumes the source holds push for one cycle and never pushes while busy.
`timescale 1ns/1ns
interface srpb_xfer_if #(parameter int W = 16);
	logic [W-1:0] sdata;
	logic         push;
	logic         busy;
	logic [W-1:0] rdata;
	logic         rvalid;
	modport src  (output sdata, output push, input busy);
	modport dst  (input rdata, input rvalid);
	modport xfer (input sdata, input push, output busy, output rdata, output rvalid);
endinterface : srpb_xfer_if

// ==== src/srpb_xfer.sv ====
// Toggle handshake that moves one word from a source clock to a destination clock.
// Assumes synchronous active-high resets, one per domain.
`timescale 1ns/1ns
module srpb_xfer (
	input wire logic src_clk,
	input wire logic src_rst,
	input wire logic src_ce,
	input wire logic dst_clk,
	input wire logic dst_rst,
	input wire logic dst_ce,
	srpb_xfer_if.xfer x
);
	logic [$bits(x.sdata)-1:0] hold;
	logic                      req_tog;
	logic                      ack_s1;
	logic                      ack_s2;
	logic                      req_s1;
	logic                      req_s2;
	logic                      req_s3;

	assign x.busy = req_tog ^ ack_s2;

	// Source side
	always_ff @(posedge src_clk) begin
		if (src_rst) begin
			hold    <= '0;
			req_tog <= 1'b0;
			ack_s1  <= 1'b0;
			ack_s2  <= 1'b0;
		end else if (src_ce) begin
			ack_s1 <= req_s3;
			ack_s2 <= ack_s1;
			if (x.push && !x.busy) begin
				hold    <= x.sdata;
				req_tog <= ~req_tog;
			end
		end
	end

	// Destination side
	always_ff @(posedge dst_clk) begin
		if (dst_rst) begin
			req_s1   <= 1'b0;
			req_s2   <= 1'b0;
			req_s3   <= 1'b0;
			x.rvalid <= 1'b0;
			x.rdata  <= '0;
		end else if (dst_ce) begin
			req_s1   <= req_tog;
			req_s2   <= req_s1;
			req_s3   <= req_s2;
			x.rvalid <= req_s2 ^ req_s3;
			if (req_s2 ^ req_s3) begin
				x.rdata <= hold;
			end
		end
	end
endmodule : srpb_xfer

// ==== verification/srpb_host_model.sv ====
// Link-side host model: drives the byte strobes of the register bank.
// Assumes a free-running link clock and reset already released.
`timescale 1ns/1ns
module srpb_host_model (
	input  wire logic       link_clk,
	input  wire logic [7:0] rdata,
	input  wire logic       busy,
	output logic            start,
	output logic            ptr_wr,
	output logic            data_wr,
	output logic            rd_next,
	output logic      [7:0] wdata,
	output logic            stalled
);
	initial begin
		start = 1'b0;
		ptr_wr = 1'b0;
		data_wr = 1'b0;
		rd_next = 1'b0;
		wdata = 8'h00;
		stalled = 1'b0;
	end

	task automatic idle_wait();
		int n;
		n = 0;
		@(posedge link_clk);
		#1;
		while (busy !== 1'b0 && n < 50) begin
			@(posedge link_clk);
			#1;
			n++;
		end
		if (n >= 50) stalled = 1'b1;
	endtask : idle_wait

	task automatic put_ptr(input logic [7:0] b);
		idle_wait();
		@(posedge link_clk);
		ptr_wr <= 1'b1;
		wdata <= b;
		@(posedge link_clk);
		ptr_wr <= 1'b0;
		wdata <= ~b;
		repeat (2) @(posedge link_clk);
	endtask : put_ptr

	task automatic put_word(input logic [15:0] w);
		idle_wait();
		@(posedge link_clk);
		start <= 1'b1;
		@(posedge link_clk);
		start <= 1'b0;
		data_wr <= 1'b1;
		wdata <= w[15:8];
		@(posedge link_clk);
		wdata <= w[7:0];
		@(posedge link_clk);
		data_wr <= 1'b0;
		wdata <= ~w[7:0];
		repeat (2) @(posedge link_clk);
	endtask : put_word

	task automatic get_word(output logic [15:0] w);
		@(posedge link_clk);
		start <= 1'b1;
		@(posedge link_clk);
		start <= 1'b0;
		repeat (3) @(posedge link_clk);
		#1;
		w[15:8] = rdata;
		@(posedge link_clk);
		rd_next <= 1'b1;
		@(posedge link_clk);
		rd_next <= 1'b0;
		repeat (2) @(posedge link_clk);
		#1;
		w[7:0] = rdata;
	endtask : get_word
endmodule : srpb_host_model

// ==== verification/tb.sv ====
// Self-checking bench for the register pointer bank.
// Assumes short pace counts of 40, 20, 10 and 5 core cycles.
`timescale 1ns/1ns
module tb;
	import srpb_pkg::*;
	localparam int CYC_T [4] = '{40, 20, 10, 5};
	logic clock = 1'b0, rst = 1'b1, link_clk = 1'b0, temp_valid = 1'b0, alert_flag = 1'b0;
	logic ce = 1'b1;
	logic [15:0] temp_in = 16'h0000;
	logic start, ptr_wr, data_wr, rd_next, busy, stalled, tick;
	logic [7:0] wdata, rdata, ptr;
	logic [15:0] setup, lower, upper, w;
	logic [1:0] pace;
	int bad_count = 0, samples_checked = 0;

	always #2 clock = ~clock;
	always #3 link_clk = ~link_clk;

	srpb_top #(.CYC_00(40), .CYC_01(20), .CYC_10(10), .CYC_11(5)) srpb_top_inst (
		.CLOCK(clock), .RST(rst), .CE(ce), .LINK_CLK(link_clk), .LINK_START(start),
		.LINK_PTR_WR(ptr_wr), .LINK_DATA_WR(data_wr), .LINK_RD_NEXT(rd_next),
		.LINK_WDATA(wdata), .LINK_RDATA(rdata), .LINK_BUSY(busy), .TEMP_IN(temp_in),
		.TEMP_VALID(temp_valid), .ALERT_FLAG(alert_flag), .PTR_OUT(ptr), .SETUP_OUT(setup),
		.LOWER_OUT(lower), .UPPER_OUT(upper), .CONV_PACE(pace), .CONV_TICK(tick));

	srpb_host_model srpb_host_model_inst (.link_clk(link_clk), .rdata(rdata), .busy(busy),
		.start(start), .ptr_wr(ptr_wr), .data_wr(data_wr), .rd_next(rd_next),
		.wdata(wdata), .stalled(stalled));

	task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	task automatic wrap_up();
		if (stalled !== 1'b0) bad_count++;
		if (bad_count == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : wrap_up

	task automatic settle();
		repeat (30) @(posedge clock);
		#1;
	endtask : settle

	task automatic store(input logic [7:0] p, input logic [15:0] v);
		srpb_host_model_inst.put_ptr(p);
		srpb_host_model_inst.put_word(v);
		settle();
	endtask : store

	task automatic t_reset();
		check("pointer", ptr, 16'h0000);
		check("pace", pace, 16'h0002);
		check("setup", setup, SETUP_RESET);
	endtask : t_reset

	task automatic t_pointer();
		srpb_host_model_inst.put_ptr(8'hfe);
		settle();
		check("pointer fe", ptr, 16'h0002);
		srpb_host_model_inst.put_ptr(8'hff);
		settle();
		check("pointer ff", ptr, 16'h0003);
	endtask : t_pointer

	task automatic t_setup();
		@(posedge clock);
		alert_flag <= 1'b1;
		store(8'h01, 16'hffff);
		check("setup", setup, 16'h9fc0);
		check("pace", pace, 16'h0003);
		srpb_host_model_inst.get_word(w);
		check("setup read", w, 16'hdfe0);
	endtask : t_setup

	task automatic t_thresholds();
		store(8'h02, 16'h1234);
		store(8'h03, 16'hab5c);
		check("lower", lower, 16'h1234);
		check("upper", upper, 16'hab5c);
		srpb_host_model_inst.get_word(w);
		check("upper read", w, 16'hab5c);
	endtask : t_thresholds

	task automatic t_temperature();
		@(posedge clock);
		temp_in <= 16'h5a3c;
		temp_valid <= 1'b1;
		@(posedge clock);
		temp_valid <= 1'b0;
		store(8'h00, 16'hffff);
		check("lower kept", lower, 16'h1234);
		repeat (2) begin
			srpb_host_model_inst.get_word(w);
			check("temp read", w, 16'h5a3c);
		end
	endtask : t_temperature

	task automatic tick_gap(output int n);
		n = 0;
		do begin
			@(posedge clock);
			#1;
			n++;
		end while (tick !== 1'b1 && n < 200);
		if (n >= 200) begin
			bad_count++;
			wrap_up();
		end
	endtask : tick_gap

	task automatic t_pace();
		int n;
		for (int c = 0; c < 4; c++) begin
			store(8'h01, {8'h00, c[1:0], 6'h00});
			check("pace", pace, {14'h0, c[1:0]});
			tick_gap(n);
			tick_gap(n);
			check("tick gap", n[15:0], CYC_T[c][15:0]);
		end
	endtask : t_pace

	task automatic t_freeze();
		logic held;
		int   moved;
		int   n;
		moved = 0;
		@(posedge clock);
		ce <= 1'b0;
		@(posedge clock);
		#1;
		held = tick;
		repeat (12) begin
			@(posedge clock);
			#1;
			if (tick !== held) moved++;
		end
		check("tick frozen", moved[15:0], 16'h0000);
		check("pace frozen", pace, 16'h0003);
		@(posedge clock);
		ce <= 1'b1;
		tick_gap(n);
		tick_gap(n);
		check("tick gap after freeze", n[15:0], CYC_T[3][15:0]);
	endtask : t_freeze

	initial begin
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		settle();
		t_reset();
		t_pointer();
		t_setup();
		t_thresholds();
		t_temperature();
		t_pace();
		t_freeze();
		wrap_up();
	end
endmodule : tb
